// file: mcs_pkg.sv
// Purpose: Constants and carrier types of the memory and peripheral chip select unit
// Assumes: One 10 MHz clock, synchronous active-low reset
// Notes: Selects and strobes are active low; 1 = deasserted
// Operation
// - Assert lower select for memory accesses inside programmable lower block up to 512K.
// - Lower region bus width selectable as 8 or 16 bits.
// - Float lower select during bus-hold or reset.
// - Assert the matching one of four midrange selects for midrange block accesses.
// - Midrange selects configurable for 8 or 16 bit bus width.
// - Float all midrange selects during bus-hold and reset.
// - Option makes midrange select 0 cover the whole midrange range.
// - Midrange selects timed to the multiplexed bus address phase.
// - Assert matching one of eight peripheral selects; I/O or memory space, programmable base.
// - Float all peripheral selects during bus-hold and reset.
// - Peripheral selects timed to the multiplexed bus address phase.
// - Upper and lower selects assert with early nonmultiplexed address timing.
// - Assert upper select for accesses inside programmable upper block up to 512K.
// - Float upper select during bus-hold and reset.
// - Upper region reset bus width set by the boot width strap.
// - After reset upper select covers 64K from F0000h including FFFF0h.
// - DRAM on upper or lower region puts column strobes on shared midrange pins.
// - Column strobe 0 qualifies low byte writes, strobe 1 high byte writes.
// - Upper DRAM drives row strobe 1 on the shared midrange select pin.
// - Lower DRAM drives row strobe 0 in place of lower select.
package mcs_pkg;
	localparam int ADDR_W = 20;
	localparam int MID_N = 4;
	localparam int PER_N = 8;
	localparam logic [19:0] MAX_BLOCK = 20'h80000;
	localparam logic [19:0] UPPER_RST_BASE = 20'hf0000;
	localparam logic [19:0] UPPER_RST_SIZE = 20'h10000;
	localparam logic [19:0] PER_REGION_SIZE = 20'h00100;
	localparam int PER_SHIFT = 8;
	localparam int CAS_MID_LO = 2;
	localparam int CAS_MID_HI = 1;
	localparam int RAS_MID = 3;

	typedef struct packed {
		logic [19:0] base;
		logic [19:0] size;
		logic isDram;
		logic width16;
	} mcs_region_t;

	typedef struct packed {
		logic [19:0] base;
		logic [19:0] size;
		logic width16;
		logic wholeRange;
	} mcs_mid_cfg_t;

	typedef struct packed {
		logic [19:0] base;
		logic ioSpace;
	} mcs_per_cfg_t;

	typedef struct packed {
		logic [19:0] addr;
		logic isIo;
		logic early;
		logic muxPhase;
		logic active;
	} mcs_cycle_t;

	typedef struct packed {
		logic lower;
		logic upper;
		logic [3:0] mid;
		logic [7:0] per;
		logic [1:0] cas;
		logic [1:0] ras;
	} mcs_sel_t;
endpackage

// file: mcs_range.sv
`timescale 1ns/1ps
// Purpose: Range hit test for one address window
// Assumes: Size is clipped to the given limit
// Notes: Purely combinational
module mcs_range (
	// Window
	input wire logic [19:0] base,
	input wire logic [19:0] size,
	input wire logic [19:0] limit,
	// Address
	input wire logic [19:0] addr,
	// Result
	output logic hit
);
	logic [19:0] effSize;
	logic [20:0] top;
	always_comb begin
		effSize = (size > limit) ? limit : size;
		top = {1'b0, base} + {1'b0, effSize};
		hit = ({1'b0, addr} >= {1'b0, base}) && ({1'b0, addr} < top);
	end
endmodule

// file: mcs_pins.sv
`timescale 1ns/1ps
// Purpose: Output stage of the select pins with three-state control
// Assumes: Pullups on the board hold floating pins high
// Notes: Enable high while driving
module mcs_pins (
	// Control
	input wire logic float,
	// Select levels
	input wire mcs_pkg::mcs_sel_t sel,
	// Pins
	output mcs_pkg::mcs_sel_t pinOut,
	output logic pinOe
);
	always_comb begin
		pinOut = float ? '1 : sel;
		pinOe = ~float;
	end
endmodule

// file: mcs_chip_select.sv
`timescale 1ns/1ps
// Purpose: Address decode and chip select / DRAM strobe generation
// Assumes: Cycle info synchronous to core_clk; configuration stable during cycles
// Notes: Pins lowerSel/rowStrobe0 and mid1-3 / col/row strobes share pads
module mcs_chip_select (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Bus cycle
	input wire mcs_pkg::mcs_cycle_t cycle,
	input wire logic write_low_byte_n,
	input wire logic write_high_byte_n,
	input wire logic busHold,
	// Strap
	input wire logic upper_boot_width_strap,
	// Configuration
	input wire logic cfgLoad,
	input wire mcs_pkg::mcs_region_t upperCfg,
	input wire mcs_pkg::mcs_region_t lowerCfg,
	input wire mcs_pkg::mcs_mid_cfg_t midCfg,
	input wire mcs_pkg::mcs_per_cfg_t perCfg,
	// Pins
	output logic lower_mem_select_n,
	output logic upper_mem_select_n,
	output logic [3:0] mid_mem_select_n,
	output logic [7:0] periph_select_n,
	output logic selOe,
	// Status
	output logic busWidth16,
	output logic upperWidth16
);
	typedef enum logic [2:0] {
		ST_RESET = 3'b001,
		ST_BOOT = 3'b010,
		ST_RUN = 3'b100
	} mcs_state_t;

	typedef struct packed {
		mcs_state_t st;
		mcs_pkg::mcs_region_t up;
		mcs_pkg::mcs_region_t lo;
		mcs_pkg::mcs_mid_cfg_t mid;
		mcs_pkg::mcs_per_cfg_t per;
		mcs_pkg::mcs_sel_t sel;
		logic width16;
		logic strapW16;
		logic inReset;
	} mcs_regs_t;

	mcs_regs_t r;
	mcs_regs_t next_r;
	logic hitUp;
	logic hitLo;
	logic hitMid;
	logic [3:0] hitMidSub;
	logic [7:0] hitPer;
	logic [19:0] midSub;
	mcs_pkg::mcs_sel_t pinVal;
	logic pinEn;

	mcs_range uUp (
		.base(r.up.base),
		.size(r.up.size),
		.limit(mcs_pkg::MAX_BLOCK),
		.addr(cycle.addr),
		.hit(hitUp)
	);
	mcs_range uLo (
		.base(r.lo.base),
		.size(r.lo.size),
		.limit(mcs_pkg::MAX_BLOCK),
		.addr(cycle.addr),
		.hit(hitLo)
	);
	mcs_range uMid (
		.base(r.mid.base),
		.size(r.mid.size),
		.limit(mcs_pkg::MAX_BLOCK),
		.addr(cycle.addr),
		.hit(hitMid)
	);

	assign midSub = r.mid.size >> 2;
	genvar gi;
	generate
		for (gi = 0; gi < mcs_pkg::MID_N; gi++) begin : gMid
			logic [19:0] off;
			assign off = cycle.addr - r.mid.base;
			assign hitMidSub[gi] = hitMid && (midSub != 20'h00000)
				&& ((off / midSub) == 20'(gi));
		end
		for (gi = 0; gi < mcs_pkg::PER_N; gi++) begin : gPer
			logic [19:0] lo;
			assign lo = r.per.base + 20'(gi << mcs_pkg::PER_SHIFT);
			assign hitPer[gi] = (cycle.addr >= lo)
				&& (cycle.addr < lo + mcs_pkg::PER_REGION_SIZE)
				&& (cycle.isIo == r.per.ioSpace);
		end
	endgenerate

	always_comb begin
		next_r = r;
		next_r.sel = '1;
		next_r.width16 = 1'b0;
		next_r.inReset = 1'b0;
		case (r.st)
			ST_RESET: begin
				next_r.strapW16 = ~upper_boot_width_strap;
				next_r.up.base = mcs_pkg::UPPER_RST_BASE;
				next_r.up.size = mcs_pkg::UPPER_RST_SIZE;
				next_r.up.isDram = 1'b0;
				next_r.up.width16 = ~upper_boot_width_strap;
				next_r.st = ST_BOOT;
			end
			ST_BOOT, ST_RUN: begin
				if (cfgLoad) begin
					next_r.up = upperCfg;
					next_r.lo = lowerCfg;
					next_r.mid = midCfg;
					next_r.per = perCfg;
					next_r.st = ST_RUN;
				end
				if (cycle.active && !cycle.isIo) begin
					if (cycle.early) begin
						if (hitUp && !r.up.isDram) begin
							next_r.sel.upper = 1'b0;
						end
						if (hitUp && r.up.isDram) begin
							next_r.sel.ras[1] = 1'b0;
						end
						if (hitLo && !r.lo.isDram) begin
							next_r.sel.lower = 1'b0;
						end
						if (hitLo && r.lo.isDram) begin
							next_r.sel.ras[0] = 1'b0;
						end
						if (hitUp) begin
							next_r.width16 = r.up.width16;
						end else if (hitLo) begin
							next_r.width16 = r.lo.width16;
						end
					end
					if (cycle.muxPhase && hitMid) begin
						if (r.mid.wholeRange) begin
							next_r.sel.mid[0] = 1'b0;
						end else begin
							next_r.sel.mid = ~hitMidSub;
						end
						next_r.width16 = r.mid.width16;
					end
					if (cycle.muxPhase && ((hitUp && r.up.isDram) || (hitLo && r.lo.isDram))) begin
						next_r.sel.cas[0] = write_low_byte_n;
						next_r.sel.cas[1] = write_high_byte_n;
					end
				end
				if (cycle.active && cycle.muxPhase) begin
					next_r.sel.per = ~hitPer;
				end
			end
			default: begin
				next_r.st = ST_RESET;
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			r <= '0;
			r.st <= ST_RESET;
			r.sel <= '1;
			r.inReset <= 1'b1;
		end else begin
			r <= next_r;
		end
	end

	mcs_pins uPins (
		.float(busHold || r.inReset || !rst_n),
		.sel(r.sel),
		.pinOut(pinVal),
		.pinOe(pinEn)
	);

	always_comb begin
		lower_mem_select_n = r.lo.isDram ? pinVal.ras[0] : pinVal.lower;
		upper_mem_select_n = pinVal.upper;
		periph_select_n = pinVal.per;
		mid_mem_select_n = pinVal.mid;
		if (r.up.isDram || r.lo.isDram) begin
			mid_mem_select_n[mcs_pkg::CAS_MID_LO] = pinVal.cas[0];
			mid_mem_select_n[mcs_pkg::CAS_MID_HI] = pinVal.cas[1];
		end
		if (r.up.isDram) begin
			mid_mem_select_n[mcs_pkg::RAS_MID] = pinVal.ras[1];
		end
		selOe = pinEn;
		busWidth16 = r.width16;
		upperWidth16 = r.up.width16;
	end

	idle_high_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		!$past(cycle.active) |-> r.sel == '1) else $error("select active outside cycle");
	boot_fetch_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		(r.st == ST_BOOT && cycle.active && cycle.early && !cycle.isIo
		&& cycle.addr == 20'hffff0) |=> !r.sel.upper) else $error("boot fetch missed");
	hold_float_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		busHold |-> !selOe && upper_mem_select_n) else $error("driven in hold");
	mid_whole_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		r.mid.wholeRange |-> r.sel.mid[3:1] == 3'h7) else $error("mid subregion on");
	mid_timing_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		!$past(cycle.muxPhase) |-> r.sel.mid == 4'hf) else $error("mid early");
	per_timing_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		!$past(cycle.muxPhase) |-> r.sel.per == 8'hff) else $error("per early");
	per_onehot_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		$countones(~r.sel.per) <= 1) else $error("two periph selects");
	lo_dram_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		r.lo.isDram |-> r.sel.lower) else $error("lower select in DRAM mode");
	cas_byte_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		!r.sel.cas[0] |-> $past(write_low_byte_n) == 1'b0) else $error("cas0 mismatch");

	cov_upper: cover property (@(posedge core_clk) !r.sel.upper);
	cov_per: cover property (@(posedge core_clk) r.sel.per != 8'hff);
	cov_ras: cover property (@(posedge core_clk) r.sel.ras != 2'h3);
	cov_mid: cover property (@(posedge core_clk) r.sel.mid != 4'hf);
	cov_cas: cover property (@(posedge core_clk) r.sel.cas != 2'h3);

	reset_float_a: assert property (@(posedge core_clk)
		!rst_n |-> !selOe && lower_mem_select_n && upper_mem_select_n
		&& mid_mem_select_n == 4'hf && periph_select_n == 8'hff) else $error("driven in reset");

	hold_lower_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		busHold |-> lower_mem_select_n) else $error("lower driven in hold");

	hold_mid_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		busHold |-> mid_mem_select_n == 4'hf) else $error("midrange driven in hold");

	hold_per_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		busHold |-> periph_select_n == 8'hff) else $error("peripheral driven in hold");

	run_drive_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		!busHold && r.st != ST_RESET |-> selOe) else $error("pins floated in run");

	upper_hit_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		cycle.active && cycle.early && !cycle.isIo && hitUp && !r.up.isDram
		&& r.st != ST_RESET |=> !r.sel.upper) else $error("upper select missed");

	lower_hit_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		cycle.active && cycle.early && !cycle.isIo && hitLo && !r.lo.isDram
		&& r.st != ST_RESET |=> !r.sel.lower) else $error("lower select missed");

	ras1_hit_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		cycle.active && cycle.early && !cycle.isIo && hitUp && r.up.isDram
		&& r.st != ST_RESET |=> !r.sel.ras[1]) else $error("row strobe 1 missed");

	ras0_hit_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		cycle.active && cycle.early && !cycle.isIo && hitLo && r.lo.isDram
		&& r.st != ST_RESET |=> !r.sel.ras[0]) else $error("row strobe 0 missed");

	lower_width_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		cycle.active && cycle.early && !cycle.isIo && hitLo && !hitUp && !cycle.muxPhase
		&& r.st != ST_RESET |=> busWidth16 == $past(r.lo.width16)) else $error("lower width");

	mid_width_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		cycle.active && cycle.muxPhase && !cycle.isIo && hitMid && r.st != ST_RESET
		|=> busWidth16 == $past(r.mid.width16)) else $error("midrange width");

	early_only_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		!$past(cycle.early) |-> r.sel.upper && r.sel.lower && r.sel.ras == 2'h3)
		else $error("upper or lower select late");

	cas_mux_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		!$past(cycle.muxPhase) |-> r.sel.cas == 2'h3) else $error("column strobe early");

	cas_hi_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		!r.sel.cas[1] |-> $past(write_high_byte_n) == 1'b0) else $error("cas1 mismatch");

	mid_onehot_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		$countones(~r.sel.mid) <= 1) else $error("two midrange selects");

	mid_sub_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		cycle.active && cycle.muxPhase && !cycle.isIo && hitMidSub[0] && r.st != ST_RESET
		|=> !r.sel.mid[0]) else $error("midrange select 0 missed");

	mid_whole_hit_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		cycle.active && cycle.muxPhase && !cycle.isIo && hitMid && r.mid.wholeRange
		&& r.st != ST_RESET |=> !r.sel.mid[0]) else $error("whole range select missed");

	per_space_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		cycle.active && cycle.muxPhase && cycle.isIo != r.per.ioSpace
		|=> r.sel.per == 8'hff) else $error("peripheral select in wrong space");

	io_no_mem_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		cycle.active && cycle.isIo |=> r.sel.upper && r.sel.lower && r.sel.mid == 4'hf
		&& r.sel.ras == 2'h3 && r.sel.cas == 2'h3) else $error("memory select on I/O");

	boot_window_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		r.st == ST_BOOT |-> r.up.base == mcs_pkg::UPPER_RST_BASE
		&& r.up.size == mcs_pkg::UPPER_RST_SIZE) else $error("boot window wrong");

	strap_width_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		$past(r.st) == ST_RESET && r.st == ST_BOOT
		|-> upperWidth16 == !$past(upper_boot_width_strap)) else $error("boot width wrong");

	strap_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		r.st == ST_BOOT |-> upperWidth16 == r.strapW16) else $error("boot width lost");

	mid_pin_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		!r.up.isDram && !r.lo.isDram && selOe |-> mid_mem_select_n == r.sel.mid)
		else $error("midrange pin mismatch");

	ras0_pin_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		r.lo.isDram && selOe |-> lower_mem_select_n == r.sel.ras[0]) else $error("ras0 pin");
endmodule

// file: mcs_ext_bus.sv
`timescale 1ns/1ps
// Purpose: Board side of the select pins: pullups and the level the devices see
// Assumes: Pullups hold undriven select pins high
// Notes: Order of seen is lower, upper, mid[3:0], per[7:0]
module mcs_ext_bus (
	// Driven pins
	input wire logic selOe,
	input wire logic lowerN,
	input wire logic upperN,
	input wire logic [3:0] midN,
	input wire logic [7:0] perN,
	// Levels seen by memories and peripherals
	output logic [13:0] seen
);
	assign seen = selOe ? {lowerN, upperN, midN, perN} : 14'h3fff;
endmodule

// file: mcs_chip_select_tb.sv
`timescale 1ns/1ps
// Purpose: Self-checking bench of the chip select unit
// Assumes: Outputs answer one clock after the qualifying phase edge
// Notes: Random mid and peripheral addresses from a fixed seed
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_count++; \
	$display("mismatch t=%0t got %h exp %h", $time, a, b); end end
module mcs_chip_select_tb;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	mcs_pkg::mcs_cycle_t cycle = '0;
	logic wrLowN = 1'b1, wrHighN = 1'b1, busHold = 1'b0, strap = 1'b0, cfgLoad = 1'b0;
	mcs_pkg::mcs_region_t upperCfg = '0, lowerCfg = '0;
	mcs_pkg::mcs_mid_cfg_t midCfg = '0;
	mcs_pkg::mcs_per_cfg_t perCfg = '0;
	logic lowerN, upperN, selOe, busWidth16, upperWidth16;
	logic [3:0] midN;
	logic [7:0] perN;
	logic [13:0] seen;
	int err_count = 0, check_count = 0, seed = 32'hf973, r, i;
	logic [19:0] a;

	always #50 core_clk = ~core_clk;

	mcs_chip_select dut (.core_clk(core_clk), .rst_n(rst_n), .cycle(cycle),
		.write_low_byte_n(wrLowN), .write_high_byte_n(wrHighN), .busHold(busHold),
		.upper_boot_width_strap(strap), .cfgLoad(cfgLoad), .upperCfg(upperCfg),
		.lowerCfg(lowerCfg), .midCfg(midCfg), .perCfg(perCfg),
		.lower_mem_select_n(lowerN), .upper_mem_select_n(upperN),
		.mid_mem_select_n(midN), .periph_select_n(perN), .selOe(selOe),
		.busWidth16(busWidth16), .upperWidth16(upperWidth16));
	mcs_ext_bus board (.selOe(selOe), .lowerN(lowerN), .upperN(upperN), .midN(midN),
		.perN(perN), .seen(seen));

	task automatic acc(input logic [19:0] ad, input logic io, input logic e, input logic m);
		@(posedge core_clk);
		cycle <= '{addr: ad, isIo: io, early: e, muxPhase: m, active: 1'b1};
		@(posedge core_clk);
		cycle <= '0;
		#1;
	endtask

	function automatic logic [3:0] midExp(input logic [19:0] ad);
		return ~(4'h1 << ((ad - 20'h80000) >> 12));
	endfunction

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	initial begin
		#(3000 * 100);
		err_count++;
		report_and_stop;
	end

	initial begin
		repeat (10) @(posedge core_clk);
		#1;
		`CHK(seen, 14'h3fff)
		`CHK(selOe, 1'b0)
		repeat (10) @(posedge core_clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge core_clk);
		acc(20'hffff0, 1'b0, 1'b1, 1'b0);
		`CHK(upperN, 1'b0)
		`CHK(upperWidth16, 1'b1)
		acc(20'hefff0, 1'b0, 1'b1, 1'b0);
		`CHK(seen, 14'h3fff)
		$display("boot window done");
		upperCfg <= '{base: 20'he0000, size: 20'h20000, isDram: 1'b0, width16: 1'b1};
		lowerCfg <= '{base: 20'h00000, size: 20'h10000, isDram: 1'b0, width16: 1'b0};
		midCfg <= '{base: 20'h80000, size: 20'h04000, width16: 1'b1, wholeRange: 1'b0};
		perCfg <= '{base: 20'h40000, ioSpace: 1'b1};
		cfgLoad <= 1'b1;
		@(posedge core_clk);
		cfgLoad <= 1'b0;
		acc(20'he8000, 1'b0, 1'b1, 1'b0);
		`CHK(upperN, 1'b0)
		`CHK(busWidth16, 1'b1)
		acc(20'h0fffe, 1'b0, 1'b1, 1'b0);
		`CHK(lowerN, 1'b0)
		`CHK(busWidth16, 1'b0)
		@(posedge core_clk);
		#1;
		`CHK(seen, 14'h3fff)
		acc(20'h81000, 1'b0, 1'b1, 1'b0);
		`CHK(midN, 4'hf)
		acc(20'h40100, 1'b1, 1'b1, 1'b0);
		`CHK(perN, 8'hff)
		for (i = 0; i < 24; i++) begin
			r = $random(seed);
			a = 20'h80000 + 20'(r[13:0]);
			acc(a, 1'b0, 1'b0, 1'b1);
			`CHK(midN, midExp(a))
			`CHK(busWidth16, 1'b1)
			a = 20'h40000 + {9'h0, r[18:16], r[7:0]};
			acc(a, 1'b1, 1'b0, 1'b1);
			`CHK(perN, ~(8'h1 << r[18:16]))
		end
		acc(20'h40200, 1'b0, 1'b0, 1'b1);
		`CHK(perN, 8'hff)
		$display("random decode done");
		busHold <= 1'b1;
		acc(20'h0fffe, 1'b0, 1'b1, 1'b1);
		`CHK(seen, 14'h3fff)
		`CHK(selOe, 1'b0)
		busHold <= 1'b0;
		midCfg.wholeRange <= 1'b1;
		cfgLoad <= 1'b1;
		@(posedge core_clk);
		cfgLoad <= 1'b0;
		acc(20'h83ffe, 1'b0, 1'b0, 1'b1);
		`CHK(midN, 4'he)
		$display("hold and whole range done");
		lowerCfg.isDram <= 1'b1;
		upperCfg.isDram <= 1'b1;
		cfgLoad <= 1'b1;
		@(posedge core_clk);
		cfgLoad <= 1'b0;
		acc(20'h00100, 1'b0, 1'b1, 1'b0);
		`CHK(lowerN, 1'b0)
		wrLowN <= 1'b0;
		acc(20'h00100, 1'b0, 1'b0, 1'b1);
		`CHK(midN[2:1], 2'b01)
		wrLowN <= 1'b1;
		wrHighN <= 1'b0;
		acc(20'h00100, 1'b0, 1'b0, 1'b1);
		`CHK(midN[2:1], 2'b10)
		wrHighN <= 1'b1;
		acc(20'hf0100, 1'b0, 1'b1, 1'b0);
		`CHK(midN[3], 1'b0)
		`CHK(lowerN, 1'b1)
		$display("dram strobes done");
		strap <= 1'b1;
		rst_n <= 1'b0;
		repeat (3) @(posedge core_clk);
		#1;
		`CHK(seen, 14'h3fff)
		rst_n <= 1'b1;
		repeat (2) @(posedge core_clk);
		acc(20'hffff0, 1'b0, 1'b1, 1'b0);
		`CHK(upperN, 1'b0)
		`CHK(upperWidth16, 1'b0)
		`CHK(busWidth16, 1'b0)
		`CHK(midN, 4'hf)
		$display("reset with 8-bit strap done");
		report_and_stop;
	end
endmodule
